// ---- hms_mode_bits.sv ----
// Module: remote transceiver mode select and proposal bit encoder behind APB
//
// Behaviour
// - Select sets annex bits to one
// - Proposal sets annex bits to one
// - Subsidiary bit set brings level-3 field
// - Select: never both optional band bits
// - Proposal: never both optional band bits
// - PSD reduction bit follows request
// - Select transport bits equal capability AND
// - Proposal transport bits only when both
// - Clear overhead and cell transport agreed
// - Frame step copied from peer capability
// - Advertise packet transport only when capable
`timescale 1ns/100ps
module hms_mode_bits (
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  input  wire hms_pkg::hms_apb_req_t apb_in,
  output logic                      pready_out,
  output logic                      pslverr_out,
  output logic [31:0]               prdata_out,
  output hms_pkg::hms_par_t         msg_out,
  output logic                      msg_valid_out
);
  import hms_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  hms_kind_t         kind;
  hms_kind_t         next_kind;
  logic              ptm_can;
  logic              next_ptm_can;
  logic [PAR_W-1:0]  own_cap;
  logic [PAR_W-1:0]  next_own_cap;
  logic [PAR_W-1:0]  peer_cap;
  logic [PAR_W-1:0]  next_peer_cap;
  logic [PAR_W-1:0]  req;
  logic [PAR_W-1:0]  next_req;
  hms_par_t          msg;
  hms_par_t          next_msg;
  logic              valid;
  logic              next_valid;
  logic              clash;
  logic              next_clash;
  logic              ready;
  logic              next_ready;
  logic              slverr;
  logic              next_slverr;
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic              build;
  logic              msg_valid_kind;

  function automatic logic [31:0] widen(input logic [PAR_W-1:0] v);
    widen = {{(32 - PAR_W){1'b0}}, v};
  endfunction : widen

  // Capability word as advertised: packet transport masked by ability
  function automatic logic [PAR_W-1:0] advert(input logic [PAR_W-1:0] v,
                                              input logic             can);
    logic [PAR_W-1:0] r;
    r = v;
    r[BIT_PTM] = v[BIT_PTM] & can;
    advert = r;
  endfunction : advert

  //////////////////////////////////////////////////////////////////////////////
  // APB slave; pready is registered and rises on the second edge after setup, one wait state
  logic acc;
  logic wr;
  logic rd;
  assign acc = apb_in.psel & apb_in.penable & ~ready;
  assign wr  = acc & apb_in.pwrite;
  assign rd  = acc & ~apb_in.pwrite;
  assign build = wr && (apb_in.paddr == REG_CTRL) && apb_in.pwdata[CTRL_BUILD];

  always_comb
  begin
    next_kind     = kind;
    next_ptm_can  = ptm_can;
    next_own_cap  = own_cap;
    next_peer_cap = peer_cap;
    next_req      = req;
    next_ready    = acc;
    next_slverr   = 1'b0;
    next_rdata    = RST_WORD;
    if (wr)
    begin
      unique case (apb_in.paddr)
        REG_CTRL:
        begin
          next_kind    = hms_kind_t'(apb_in.pwdata[CTRL_KIND]);
          next_ptm_can = apb_in.pwdata[CTRL_PTM_CAN];
        end
        REG_OWNCAP: next_own_cap  = apb_in.pwdata[PAR_W-1:0];
        REG_PEERCL: next_peer_cap = apb_in.pwdata[PAR_W-1:0];
        REG_MSG:    next_req      = apb_in.pwdata[PAR_W-1:0];
        REG_STATUS: next_slverr   = 1'b1;
        default:    next_slverr   = 1'b1;
      endcase
    end
    if (rd)
    begin
      unique case (apb_in.paddr)
        REG_CTRL:
        begin
          next_rdata[CTRL_KIND]    = kind;
          next_rdata[CTRL_PTM_CAN] = ptm_can;
        end
        REG_OWNCAP: next_rdata = widen(advert(own_cap, ptm_can));
        REG_PEERCL: next_rdata = widen(peer_cap);
        REG_MSG:    next_rdata = widen(msg);
        REG_STATUS:
        begin
          next_rdata[STAT_VALID] = valid;
          next_rdata[STAT_CLASH] = clash;
          next_rdata[STAT_KIND]  = msg_valid_kind;
        end
        default:    next_slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      kind     <= HMS_SELECT;
      ptm_can  <= 1'b0;
      own_cap  <= '0;
      peer_cap <= '0;
      req      <= '0;
      ready    <= 1'b0;
      slverr   <= 1'b0;
      rdata    <= RST_WORD;
    end
    else
    begin
      kind     <= next_kind;
      ptm_can  <= next_ptm_can;
      own_cap  <= next_own_cap;
      peer_cap <= next_peer_cap;
      req      <= next_req;
      ready    <= next_ready;
      slverr   <= next_slverr;
      rdata    <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Message builder; a written request that asks for both bands is trimmed
  // to upstream only, since the line cannot carry the band both ways
  logic             next_msg_kind;
  logic [PAR_W-1:0] agreed;
  assign agreed = advert(own_cap, ptm_can) & peer_cap;

  always_comb
  begin
    next_msg      = msg;
    next_valid    = valid;
    next_clash    = clash;
    next_msg_kind = msg_valid_kind;
    if (build)
    begin
      next_msg_kind = apb_in.pwdata[CTRL_KIND];
      next_msg.mode = 1'b1;
      next_msg.optional_band_upstream   = req[BIT_OPT_UP];
      next_msg.optional_band_downstream = req[BIT_OPT_DN] & ~req[BIT_OPT_UP];
      next_clash = req[BIT_OPT_UP] & req[BIT_OPT_DN];
      next_msg.low_band_psd_reduction = req[BIT_PSD_RED];
      next_msg.ptm            = agreed[BIT_PTM];
      next_msg.atm            = agreed[BIT_ATM];
      next_msg.clear_overhead = agreed[BIT_CLR_OH];
      next_msg.frame_step_flag = peer_cap[BIT_FSTEP];
      next_msg.param3_present  = peer_cap[BIT_FSTEP];
      next_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      msg            <= '0;
      valid          <= 1'b0;
      clash          <= 1'b0;
      msg_valid_kind <= 1'b0;
    end
    else
    begin
      msg            <= next_msg;
      valid          <= next_valid;
      clash          <= next_clash;
      msg_valid_kind <= next_msg_kind;
    end
  end

  assign pready_out    = ready;
  assign pslverr_out   = slverr;
  assign prdata_out    = rdata;
  assign msg_out       = msg;
  assign msg_valid_out = valid;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_band_exclusive: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !(msg.optional_band_upstream && msg.optional_band_downstream))
    else $error("both optional band bits set");
  a_band_propose: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    build |=> !(msg_out.optional_band_upstream & msg_out.optional_band_downstream))
    else $error("proposal sets both band bits");
  a_agree_ptm: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    build |=> msg.ptm == ($past(own_cap[BIT_PTM]) & $past(ptm_can) & $past(peer_cap[BIT_PTM])))
    else $error("ptm bit not agreed value");
  a_agree_atm: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    build |=> msg.atm == ($past(own_cap[BIT_ATM]) & $past(peer_cap[BIT_ATM])))
    else $error("atm bit not agreed value");
  a_agree_overhead: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    build |=> msg.clear_overhead == ($past(own_cap[BIT_CLR_OH]) & $past(peer_cap[BIT_CLR_OH])))
    else $error("overhead bit not agreed value");
  a_frame_step: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    build && peer_cap[BIT_FSTEP] |=> msg.frame_step_flag && msg.param3_present)
    else $error("frame step not copied");
  a_psd_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    build |=> msg.low_band_psd_reduction == $past(req[BIT_PSD_RED]))
    else $error("psd bit wrong");
  a_mode_set: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    build |=> msg.mode && valid)
    else $error("mode bit not set");
  a_apb_answer: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    apb_in.psel && apb_in.penable && !ready |=> ready)
    else $error("apb answer late");

  // Setup edge, then the first access edge of a transfer
  sequence s_apb_setup;
    apb_in.psel && !apb_in.penable;
  endsequence : s_apb_setup

  sequence s_apb_first_access;
    apb_in.psel && apb_in.penable && !ready;
  endsequence : s_apb_first_access

  // Build strobe of each message kind; the new message stands one edge later
  sequence s_build_select;
    build && !apb_in.pwdata[CTRL_KIND];
  endsequence : s_build_select

  sequence s_build_propose;
    build && apb_in.pwdata[CTRL_KIND];
  endsequence : s_build_propose

  // Register bus answer shape
  a_apb_sequence: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_apb_setup ##1 s_apb_first_access |=> ready)
    else $error("apb access not answered");
  a_ready_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ready |=> !ready)
    else $error("pready held over one cycle");
  a_error_timing: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    slverr |-> ready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !ready |-> (rdata == RST_WORD))
    else $error("read data outside answer");
  a_status_refused: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wr && (apb_in.paddr == REG_STATUS) |=> slverr)
    else $error("status write not refused");

  // Message contents
  a_select_mode: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_build_select |=> msg.mode && !msg_valid_kind)
    else $error("selection not marked");
  a_propose_mode: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_build_propose |=> msg.mode && msg_valid_kind)
    else $error("proposal not marked");
  a_level3_field: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    valid |-> (msg.param3_present == msg.frame_step_flag))
    else $error("level-3 field presence wrong");
  a_band_trim: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    build && req[BIT_OPT_UP] && req[BIT_OPT_DN] |=> msg.optional_band_upstream && clash)
    else $error("both bands not trimmed");
  a_ptm_unable: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    build && !ptm_can |=> !msg.ptm)
    else $error("packet transport agreed while unable");
  a_ptm_advert: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    rd && (apb_in.paddr == REG_OWNCAP) && !ptm_can |=> !rdata[BIT_PTM])
    else $error("packet transport advertised while unable");
  a_msg_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !build |=> $stable(msg))
    else $error("message changed without build");

  // Capability storage; a stray write elsewhere must not shift the agreement
  a_own_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !(wr && (apb_in.paddr == REG_OWNCAP)) |=> $stable(own_cap))
    else $error("own capability lost");
  a_peer_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !(wr && (apb_in.paddr == REG_PEERCL)) |=> $stable(peer_cap))
    else $error("peer capability lost");
  a_own_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wr && (apb_in.paddr == REG_OWNCAP) |=> own_cap == $past(apb_in.pwdata[PAR_W-1:0]))
    else $error("own capability not stored");
  a_peer_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wr && (apb_in.paddr == REG_PEERCL) |=> peer_cap == $past(apb_in.pwdata[PAR_W-1:0]))
    else $error("peer capability not stored");

endmodule : hms_mode_bits

// ---- hms_pkg.sv ----
// Package: field layouts and message kinds for the handshake mode bit encoder
package hms_pkg;

  // APB register byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_OWNCAP = 8'h04;
  localparam logic [7:0] REG_PEERCL = 8'h08;
  localparam logic [7:0] REG_MSG    = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // Bit positions of the parameter word, shared by the capability and message registers
  localparam int BIT_OPT_UP  = 0;
  localparam int BIT_OPT_DN  = 1;
  localparam int BIT_PSD_RED = 2;
  localparam int BIT_PTM     = 3;
  localparam int BIT_ATM     = 4;
  localparam int BIT_CLR_OH  = 5;
  localparam int BIT_FSTEP   = 6;
  localparam int BIT_PARAM3  = 7;
  localparam int BIT_MODE    = 8;
  localparam int PAR_W       = 9;

  // Control register fields
  localparam int CTRL_KIND    = 0;
  localparam int CTRL_BUILD   = 1;
  localparam int CTRL_PTM_CAN = 2;

  // Status register fields
  localparam int STAT_VALID   = 0;
  localparam int STAT_CLASH   = 1;
  localparam int STAT_KIND    = 2;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic { HMS_SELECT, HMS_PROPOSE } hms_kind_t;

  // Bits placed in an outgoing select or proposal message
  typedef struct packed {
    logic mode;
    logic param3_present;
    logic frame_step_flag;
    logic clear_overhead;
    logic atm;
    logic ptm;
    logic low_band_psd_reduction;
    logic optional_band_downstream;
    logic optional_band_upstream;
  } hms_par_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } hms_apb_req_t;

endpackage : hms_pkg

// ---- hms_co_model.sv ----
// Central office side model: capability lists that it advertises
`timescale 1ns/100ps
module hms_co_model (
  input  wire logic [1:0] idx_in,
  output logic      [8:0] cl_out
);
  import hms_pkg::*;
  //////////////////////////////////////////////////////////////////////////
  // Fixed lists; a real far end never changes a list while it is in use
  always_comb
  begin
    case (idx_in)
      2'h0:    cl_out = 9'h068;
      2'h1:    cl_out = 9'h018;
      2'h2:    cl_out = 9'h078;
      default: cl_out = 9'h030;
    endcase
  end
endmodule : hms_co_model

// ---- handshake_mode_select_bits_tb.sv ----
// Testbench for the handshake mode bit encoder
`timescale 1ns/100ps
module handshake_mode_select_bits_tb;
  import hms_pkg::*;
  logic         clk = 1'h0;
  logic         rst_n = 1'h0;
  hms_apb_req_t req = '0;
  logic         pready;
  logic         pslverr;
  logic         msg_valid;
  logic [31:0]  prdata;
  logic [31:0]  rd;
  logic         err;
  hms_par_t     msg;
  logic [1:0]   idx = 2'h0;
  logic [8:0]   peer;
  logic [8:0]   exp_m;
  int           n_errors = 0;
  int           check_count = 0;
  localparam logic [8:0] OWN_V [4] = '{9'h038, 9'h038, 9'h078, 9'h028};
  localparam logic [2:0] REQ_V [4] = '{3'h3, 3'h6, 3'h4, 3'h3};
  localparam logic       KIND_V [4] = '{1'h0, 1'h1, 1'h0, 1'h1};
  localparam logic       CAN_V [4] = '{1'h1, 1'h1, 1'h0, 1'h1};
  always #2.5 clk = ~clk;
  hms_mode_bits i_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .apb_in(req),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .msg_out(msg), .msg_valid_out(msg_valid));
  hms_co_model i_co (.idx_in(idx), .cl_out(peer));
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One edge of idle first, so psel is never driven twice in one step
  // Waits for pready with no limit of its own; the watchdog ends a hang
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel:1'h1, penable:1'h0, pwrite:wr, paddr:a, pwdata:d};
    @(posedge clk);
    req.penable <= 1'h1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask : apb
  task stop_test;
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    stop_test;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    chk({22'h0, msg_valid, msg}, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      idx <= i[1:0];
      @(posedge clk);
      apb(1'h1, REG_PEERCL, {23'h0, peer});
      apb(1'h1, REG_OWNCAP, {23'h0, OWN_V[i]});
      apb(1'h1, REG_MSG, {29'h0, REQ_V[i]});
      // Ability first: a build uses the ability that stood before its own write
      apb(1'h1, REG_CTRL, {29'h0, CAN_V[i], 1'h0, KIND_V[i]});
      apb(1'h1, REG_CTRL, {29'h0, CAN_V[i], 1'h1, KIND_V[i]});
      // Both bands asked for: upstream kept, downstream dropped
      exp_m = {1'h1, peer[6], peer[6], OWN_V[i][5:4] & peer[5:4],
               OWN_V[i][3] & CAN_V[i] & peer[3], REQ_V[i][2],
               REQ_V[i][1] & ~REQ_V[i][0], REQ_V[i][0]};
      chk({22'h0, msg_valid, msg}, {22'h0, 1'h1, exp_m});
      apb(1'h0, REG_MSG, 32'h0);
      chk(rd, {23'h0, exp_m});
      apb(1'h0, REG_STATUS, 32'h0);
      chk(rd, {29'h0, KIND_V[i], REQ_V[i][0] & REQ_V[i][1], 1'h1});
      apb(1'h0, REG_OWNCAP, 32'h0);
      chk(rd, {23'h0, OWN_V[i] & {5'h1F, CAN_V[i], 3'h7}});
    end
    apb(1'h0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'h1, REG_STATUS, 32'hFF);
    chk({31'h0, err}, 32'h1);
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd, 32'h7);
    stop_test;
  end
endmodule : handshake_mode_select_bits_tb
